/* include/sup_pkg.sv */
// Purpose: constants and types for the serial-to-datagram packer
// Assumes: 125 MHz clock, AHB-Lite register access, one word per register
// Notes:
package sup_pkg;
  localparam int BUF_BYTES = 1024;
  localparam logic [10:0] CEIL_BYTES = 11'h400;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int N_RANGES = 4;
  localparam logic [31:0] MAX_SPAN_M1 = 32'h0000003F;
  localparam logic [7:0] BCAST_OCTET = 8'hFF;
  localparam logic [15:0] LISTEN_PORT_RST = 16'h0FA1;
  localparam logic [15:0] DEST_PORT_RST = 16'h0FA1;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PACK = 8'h04;
  localparam logic [7:0] OFS_GAP = 8'h08;
  localparam logic [7:0] OFS_DTMO = 8'h0C;
  localparam logic [7:0] OFS_LISTEN = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PEER_IP = 8'h18;
  localparam logic [7:0] OFS_PEER_PORT = 8'h1C;
  localparam logic [3:0] RANGE_BLK_BASE = 4'h2;
  localparam logic [1:0] RANGE_BEGIN = 2'h0;
  localparam logic [1:0] RANGE_END = 2'h1;
  localparam logic [1:0] RANGE_PORT = 2'h2;
  // control and range-port field positions
  localparam int CTRL_DYN = 0;
  localparam int CTRL_PROC_LO = 2;
  localparam int CTRL_D1EN = 4;
  localparam int CTRL_D2EN = 5;
  localparam int CTRL_D1_LO = 8;
  localparam int CTRL_D2_LO = 16;
  localparam int PORT_EN = 16;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [10:0] PACK_RST = 11'h000;
  localparam logic [15:0] GAP_RST = 16'h0000;
  localparam logic [15:0] DTMO_RST = 16'h0000;

  typedef enum logic [1:0] {
    PROC_NONE = 2'b00,
    PROC_PLUS1 = 2'b01,
    PROC_PLUS2 = 2'b10,
    PROC_STRIP = 2'b11
  } sup_proc_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_SEND = 3'b010,
    ST_NEXT = 3'b011,
    ST_DONE = 3'b100
  } sup_state_type;
endpackage

/* hw/sup_packer.sv */
// Purpose: packs serial bytes into datagrams, forwards received datagrams to serial
// Assumes: byte streams with valid/ready; datagram metadata stable for a whole datagram
// Notes: registers on AHB-Lite, writes zero wait, reads one wait state
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sup_packer
  import sup_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES,
  parameter int DEPTH = BUF_BYTES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // serial receive bytes
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_data,
  output logic ser_rx_ready,
  // serial transmit bytes
  output logic ser_tx_valid,
  output logic [7:0] ser_tx_data,
  input wire logic ser_tx_ready,
  // outgoing datagram stream
  output logic net_tx_valid,
  output logic [7:0] net_tx_data,
  output logic net_tx_last,
  output logic [31:0] net_tx_dst_ip,
  output logic [15:0] net_tx_dst_port,
  input wire logic net_tx_ready,
  // incoming datagram stream
  input wire logic net_rx_valid,
  input wire logic [7:0] net_rx_data,
  input wire logic net_rx_last,
  input wire logic [31:0] net_rx_src_ip,
  input wire logic [15:0] net_rx_src_port,
  input wire logic [15:0] net_rx_dst_port,
  output logic net_rx_ready
);
  logic [31:0] ctrl_r;
  logic [10:0] pack_len_r;
  logic [15:0] gap_ms_r, dtmo_ms_r, listen_r;
  logic [31:0] rng_begin_r [N_RANGES];
  logic [31:0] rng_end_r [N_RANGES];
  logic [16:0] rng_port_r [N_RANGES];
  logic wr_en_r, rd_pend_r;
  logic [7:0] wr_addr_r, rd_addr_r;
  logic [31:0] rd_mux;
  logic [7:0] mem [DEPTH];
  logic [10:0] cnt_r, send_len_r, send_idx_r;
  logic [1:0] extra_r;
  logic d1_seen_r;
  sup_state_type state_r;
  logic [1:0] sel_r;
  logic [5:0] off_r;
  logic bcast_r;
  logic [31:0] ms_pre_r;
  logic ms_tick;
  logic [15:0] idle_ms_r, peer_ms_r;
  logic peer_valid_r;
  logic [31:0] peer_ip_r;
  logic [15:0] peer_port_r;
  logic in_pkt_r, keep_r;

  wire logic dyn = ctrl_r[CTRL_DYN];
  wire logic d1en = ctrl_r[CTRL_D1EN];
  wire logic d2en = ctrl_r[CTRL_D2EN];
  wire logic [7:0] d1 = ctrl_r[CTRL_D1_LO +: 8];
  wire logic [7:0] d2 = ctrl_r[CTRL_D2_LO +: 8];
  wire sup_proc_type proc = sup_proc_type'(ctrl_r[CTRL_PROC_LO +: 2]);
  wire logic acc = ser_rx_valid && ser_rx_ready;
  wire logic [10:0] cnt_n = cnt_r + 11'h001;

  // register bus
  wire logic ahb_go = hsel && htrans[1] && hready;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_en_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
    end else begin
      wr_en_r <= ahb_go && hwrite;
      rd_pend_r <= ahb_go && !hwrite;
      if (ahb_go) begin
        wr_addr_r <= haddr[7:0];
        rd_addr_r <= haddr[7:0];
      end
      // one wait state on reads so a read right after a write sees the new value
      hreadyout <= !(ahb_go && !hwrite);
      if (rd_pend_r) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (rd_addr_r)
      OFS_CTRL: rd_mux = ctrl_r;
      OFS_PACK: rd_mux = {21'h000000, pack_len_r};
      OFS_GAP: rd_mux = {16'h0000, gap_ms_r};
      OFS_DTMO: rd_mux = {16'h0000, dtmo_ms_r};
      OFS_LISTEN: rd_mux = {16'h0000, listen_r};
      OFS_STATUS: rd_mux = {14'h0000, peer_valid_r, state_r != ST_IDLE, 5'h00, cnt_r};
      OFS_PEER_IP: rd_mux = peer_ip_r;
      OFS_PEER_PORT: rd_mux = {16'h0000, peer_port_r};
      default: begin
        if (rd_addr_r[7:4] >= RANGE_BLK_BASE && rd_addr_r[7:4] < RANGE_BLK_BASE + 4'h4) begin
          case (rd_addr_r[3:2])
            RANGE_BEGIN: rd_mux = rng_begin_r[2'(rd_addr_r[7:4] - RANGE_BLK_BASE)];
            RANGE_END: rd_mux = rng_end_r[2'(rd_addr_r[7:4] - RANGE_BLK_BASE)];
            RANGE_PORT: rd_mux = {15'h0000, rng_port_r[2'(rd_addr_r[7:4] - RANGE_BLK_BASE)]};
            default: rd_mux = 32'h00000000;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      pack_len_r <= PACK_RST;
      gap_ms_r <= GAP_RST;
      dtmo_ms_r <= DTMO_RST;
      listen_r <= LISTEN_PORT_RST;
    end else if (wr_en_r) begin
      case (wr_addr_r)
        OFS_CTRL: ctrl_r <= {8'h00, hwdata[23:8], 2'h0, hwdata[5:2], 1'b0, hwdata[0]};
        OFS_PACK: pack_len_r <= hwdata[10:0];
        OFS_GAP: gap_ms_r <= hwdata[15:0];
        OFS_DTMO: dtmo_ms_r <= hwdata[15:0];
        OFS_LISTEN: listen_r <= hwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // four destination ranges, each a begin, an end and a port with enable
  for (genvar i = 0; i < N_RANGES; i++) begin : g_rng
    wire logic hit = wr_en_r && wr_addr_r[7:4] == RANGE_BLK_BASE + 4'(i);
    always_ff @(posedge clk) begin
      if (rst) begin
        rng_begin_r[i] <= 32'h00000000;
        rng_end_r[i] <= 32'h00000000;
        rng_port_r[i] <= {1'b0, DEST_PORT_RST};
      end else if (hit) begin
        if (wr_addr_r[3:2] == RANGE_BEGIN) begin
          rng_begin_r[i] <= hwdata;
        end
        if (wr_addr_r[3:2] == RANGE_END) begin
          rng_end_r[i] <= hwdata;
        end
        if (wr_addr_r[3:2] == RANGE_PORT) begin
          rng_port_r[i] <= hwdata[16:0];
        end
      end
    end
  end

  // millisecond timers
  always_ff @(posedge clk) begin
    if (rst) begin
      ms_pre_r <= 32'h00000000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= ms_pre_r == 32'(MS_CYC - 1);
      ms_pre_r <= (ms_pre_r == 32'(MS_CYC - 1)) ? 32'h00000000 : ms_pre_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_ms_r <= 16'h0000;
    end else if (acc || state_r != ST_IDLE) begin
      idle_ms_r <= 16'h0000;
    end else if (ms_tick && idle_ms_r != 16'hFFFF) begin
      idle_ms_r <= idle_ms_r + 16'h0001;
    end
  end

  // packing triggers
  logic delim_hit, send_now;
  logic [10:0] len_now;
  logic [1:0] extra_nxt;
  always_comb begin
    delim_hit = 1'b0;
    send_now = 1'b0;
    len_now = cnt_n;
    extra_nxt = extra_r;
    if (acc) begin
      if (extra_r != 2'h0) begin
        extra_nxt = extra_r - 2'h1;
        send_now = extra_r == 2'h1;
      end else if (pack_len_r == 11'h000 && d1en) begin
        delim_hit = d2en ? (d1_seen_r && ser_rx_data == d2) : (ser_rx_data == d1);
      end
      if (delim_hit) begin
        case (proc)
          PROC_NONE: send_now = 1'b1;
          PROC_PLUS1: extra_nxt = 2'h1;
          PROC_PLUS2: extra_nxt = 2'h2;
          PROC_STRIP: begin
            send_now = 1'b1;
            len_now = d2en ? cnt_n - 11'h002 : cnt_r;
          end
          default: send_now = 1'b1;
        endcase
      end
      if (pack_len_r != 11'h000 && cnt_n == pack_len_r) begin
        send_now = 1'b1;
      end
      if (cnt_n == CEIL_BYTES) begin
        send_now = 1'b1;
      end
    end else if (state_r == ST_IDLE && gap_ms_r != 16'h0000 && cnt_r != 11'h000
                 && idle_ms_r >= gap_ms_r) begin
      send_now = 1'b1;
      len_now = cnt_r;
    end
  end

  always_ff @(posedge clk) begin
    if (acc) begin
      mem[cnt_r[9:0]] <= ser_rx_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 11'h000;
      extra_r <= 2'h0;
      d1_seen_r <= 1'b0;
      send_len_r <= 11'h000;
    end else begin
      if (acc) begin
        cnt_r <= cnt_n;
        extra_r <= send_now ? 2'h0 : extra_nxt;
        d1_seen_r <= d2en && ser_rx_data == d1 && !delim_hit;
      end
      if (send_now) begin
        send_len_r <= len_now;
      end
      if (state_r == ST_DONE) begin
        cnt_r <= 11'h000;
        d1_seen_r <= 1'b0;
        // a gap flush can leave a trailing-byte count pending; it must not leak into the next buffer
        extra_r <= 2'h0;
      end
    end
  end

  // datagram sender
  logic rng_on;
  logic [31:0] span;
  logic [5:0] last_off;
  always_comb begin
    rng_on = rng_port_r[sel_r][PORT_EN];
    span = rng_end_r[sel_r] - rng_begin_r[sel_r];
    if (rng_begin_r[sel_r][7:0] == BCAST_OCTET || rng_end_r[sel_r] < rng_begin_r[sel_r]) begin
      last_off = 6'h00;
    end else if (span > MAX_SPAN_M1) begin
      last_off = 6'h3F;
    end else begin
      last_off = span[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ser_rx_ready <= 1'b1;
      sel_r <= 2'h0;
      off_r <= 6'h00;
      bcast_r <= 1'b0;
      send_idx_r <= 11'h000;
      net_tx_valid <= 1'b0;
      net_tx_data <= 8'h00;
      net_tx_last <= 1'b0;
      net_tx_dst_ip <= 32'h00000000;
      net_tx_dst_port <= 16'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (send_now) begin
            // source stalls while the buffer drains; no second buffer
            ser_rx_ready <= 1'b0;
            state_r <= ST_SETUP;
            sel_r <= 2'h0;
            off_r <= 6'h00;
          end
        end
        ST_SETUP: begin
          send_idx_r <= 11'h000;
          bcast_r <= 1'b0;
          if (send_len_r == 11'h000) begin
            state_r <= ST_DONE;
          end else if (dyn) begin
            net_tx_dst_ip <= peer_ip_r;
            net_tx_dst_port <= peer_port_r;
            state_r <= peer_valid_r ? ST_SEND : ST_DONE;
          end else if (rng_on) begin
            net_tx_dst_ip <= rng_begin_r[sel_r] + {26'h0000000, off_r};
            net_tx_dst_port <= rng_port_r[sel_r][15:0];
            bcast_r <= rng_begin_r[sel_r][7:0] == BCAST_OCTET;
            state_r <= ST_SEND;
          end else begin
            state_r <= ST_NEXT;
          end
        end
        ST_SEND: begin
          if (!net_tx_valid || net_tx_ready) begin
            if (send_idx_r < send_len_r) begin
              net_tx_valid <= 1'b1;
              net_tx_data <= mem[send_idx_r[9:0]];
              net_tx_last <= send_idx_r == send_len_r - 11'h001;
              send_idx_r <= send_idx_r + 11'h001;
            end else begin
              net_tx_valid <= 1'b0;
              net_tx_last <= 1'b0;
              state_r <= dyn ? ST_DONE : ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          if (!bcast_r && rng_on && off_r < last_off) begin
            off_r <= off_r + 6'h01;
            state_r <= ST_SETUP;
          end else begin
            off_r <= 6'h00;
            sel_r <= sel_r + 2'h1;
            state_r <= (sel_r == 2'(N_RANGES - 1)) ? ST_DONE : ST_SETUP;
          end
        end
        ST_DONE: begin
          ser_rx_ready <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // receive path
  wire logic beat = net_rx_valid && net_rx_ready;
  wire logic same_src = net_rx_src_ip == peer_ip_r && net_rx_src_port == peer_port_r;
  wire logic accept_new = net_rx_dst_port == listen_r
    && (!dyn || !peer_valid_r || dtmo_ms_r == 16'h0000 || same_src);
  wire logic keep_now = in_pkt_r ? keep_r : accept_new;
  wire logic tx_v_nxt = (ser_tx_valid && !ser_tx_ready) || (beat && keep_now);

  always_ff @(posedge clk) begin
    if (rst) begin
      in_pkt_r <= 1'b0;
      keep_r <= 1'b0;
      net_rx_ready <= 1'b1;
      ser_tx_valid <= 1'b0;
      ser_tx_data <= 8'h00;
    end else begin
      if (beat) begin
        in_pkt_r <= !net_rx_last;
        keep_r <= keep_now;
      end
      if (beat && keep_now) begin
        ser_tx_data <= net_rx_data;
      end
      ser_tx_valid <= tx_v_nxt;
      net_rx_ready <= !tx_v_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      peer_valid_r <= 1'b0;
      peer_ip_r <= 32'h00000000;
      peer_port_r <= 16'h0000;
      peer_ms_r <= 16'h0000;
    end else if (beat && !in_pkt_r && accept_new && dyn) begin
      peer_valid_r <= 1'b1;
      peer_ip_r <= net_rx_src_ip;
      peer_port_r <= net_rx_src_port;
      peer_ms_r <= 16'h0000;
    end else if (peer_valid_r && dtmo_ms_r != 16'h0000 && peer_ms_r >= dtmo_ms_r) begin
      peer_valid_r <= 1'b0;
    end else if (ms_tick && peer_ms_r != 16'hFFFF) begin
      peer_ms_r <= peer_ms_r + 16'h0001;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_count_send;
    acc && pack_len_r != 11'h000 && cnt_n == pack_len_r |=> state_r == ST_SETUP && send_len_r == $past(cnt_n);
  endproperty
  a_count_send: assert property (p_count_send) else $error("count threshold did not send");

  property p_ceiling;
    acc && cnt_r == CEIL_BYTES - 11'h001 |=> !ser_rx_ready ##1 state_r != ST_IDLE;
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("ceiling did not send");

  property p_delim_plain;
    acc && extra_r == 2'h0 && pack_len_r == 11'h000 && d1en && !d2en && ser_rx_data == d1
      && proc == PROC_NONE |=> state_r == ST_SETUP && send_len_r == $past(cnt_n);
  endproperty
  a_delim_plain: assert property (p_delim_plain) else $error("delimiter did not send");

  property p_delim_ignored;
    acc && pack_len_r != 11'h000 && cnt_n < pack_len_r && cnt_n != CEIL_BYTES |=> state_r == ST_IDLE;
  endproperty
  a_delim_ignored: assert property (p_delim_ignored) else $error("send below threshold");

  property p_plus_one;
    acc && extra_r == 2'h1 |=> state_r == ST_SETUP;
  endproperty
  a_plus_one: assert property (p_plus_one) else $error("trailing byte did not send");

  property p_strip;
    acc && delim_hit && proc == PROC_STRIP && !d2en |=> send_len_r == $past(cnt_r);
  endproperty
  a_strip: assert property (p_strip) else $error("delimiter not stripped");

  property p_dyn_dest;
    state_r == ST_SETUP && dyn && send_len_r != 11'h000
      |=> net_tx_dst_ip == $past(peer_ip_r) && net_tx_dst_port == $past(peer_port_r);
  endproperty
  a_dyn_dest: assert property (p_dyn_dest) else $error("dynamic destination not used");

  property p_span;
    state_r == ST_SEND && !dyn |-> net_tx_dst_ip - rng_begin_r[sel_r] <= MAX_SPAN_M1
      && (!bcast_r || net_tx_dst_ip == rng_begin_r[sel_r]);
  endproperty
  a_span: assert property (p_span) else $error("range span exceeded");

  property p_bcast;
    state_r == ST_SEND && bcast_r |-> net_tx_dst_ip[7:0] == BCAST_OCTET;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast address wrong");

  property p_listen;
    beat && !in_pkt_r && net_rx_dst_port != listen_r |=> !ser_tx_valid;
  endproperty
  a_listen: assert property (p_listen) else $error("foreign port forwarded");

  property p_gap;
    state_r == ST_IDLE && !acc && gap_ms_r != 16'h0000 && cnt_r != 11'h000 && idle_ms_r >= gap_ms_r
      |=> !ser_rx_ready ##1 state_r != ST_IDLE;
  endproperty
  a_gap: assert property (p_gap) else $error("idle gap did not send");
endmodule
`default_nettype wire

/* tb/sup_net_host.sv */
// Purpose: remote host model, takes datagrams from the packer and sends datagrams to it
// Assumes: one datagram at a time in each direction
// Notes: slow stalls the transmit stream on every other cycle
`timescale 1ns/1ps
`default_nettype none
module sup_net_host (
  // clock and control
  input wire logic clk,
  input wire logic slow,
  // datagrams from the packer
  input wire logic net_tx_valid,
  input wire logic [7:0] net_tx_data,
  input wire logic net_tx_last,
  input wire logic [31:0] net_tx_dst_ip,
  input wire logic [15:0] net_tx_dst_port,
  output logic net_tx_ready,
  // datagrams to the packer
  output logic net_rx_valid,
  output logic [7:0] net_rx_data,
  output logic net_rx_last,
  output logic [31:0] net_rx_src_ip,
  output logic [15:0] net_rx_src_port,
  output logic [15:0] net_rx_dst_port,
  input wire logic net_rx_ready
);
  logic [7:0] cur[$];
  logic [7:0] dg[$];
  logic [31:0] dg_ip;
  logic [15:0] dg_port;
  int ndg = 0;
  logic ph = 0;
  initial begin
    net_tx_ready = 0;
    net_rx_valid = 0;
    net_rx_data = 8'hA5;
    net_rx_last = 0;
    net_rx_src_ip = 0;
    net_rx_src_port = 0;
    net_rx_dst_port = 0;
  end
  always @(posedge clk) begin
    ph <= ~ph;
    net_tx_ready <= ~slow | ph;
    if (net_tx_valid && net_tx_ready) begin
      cur.push_back(net_tx_data);
      if (net_tx_last) begin
        dg = cur;
        cur = {};
        dg_ip = net_tx_dst_ip;
        dg_port = net_tx_dst_port;
        ndg++;
      end
    end
  end
  task automatic send(input logic [31:0] ip, input logic [15:0] sp, dp, input logic [7:0] b[$]);
    foreach (b[i]) begin
      net_rx_valid <= 1;
      net_rx_data <= b[i];
      net_rx_last <= (i == b.size() - 1);
      net_rx_src_ip <= ip;
      net_rx_src_port <= sp;
      net_rx_dst_port <= dp;
      @(negedge clk);
      while (!net_rx_ready) @(negedge clk);
      @(posedge clk);
    end
    // released data line must not keep showing the last byte
    net_rx_valid <= 0;
    net_rx_last <= 0;
    net_rx_data <= ~net_rx_data;
    // let an edge pass so a following call does not reassign valid in the same step
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* tb/sup_packer_tb_top.sv */
// Purpose: self-checking bench for the serial-to-datagram packer
// Assumes: ms tick shortened to 10 cycles, range 0 points at one host until t_rng widens it to two
// Notes: handshakes are looked at on the falling edge, released after the rising one
`timescale 1ns/1ps
`default_nettype none
module sup_packer_tb_top
  import sup_pkg::*;
;
  localparam logic [31:0] IP_A = 32'h0A000005;
  localparam logic [31:0] IP_B = 32'h0A000077;
  logic clk = 0;
  logic rst, hsel, hwrite, hreadyout, hresp, slow;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ser_rx_valid, ser_rx_ready, ser_tx_valid, ser_tx_ready;
  logic [7:0] ser_rx_data, ser_tx_data;
  logic ntv, ntl, ntr, nrv, nrl, nrr;
  logic [7:0] ntd, nrd;
  logic [31:0] nti, nri;
  logic [15:0] ntp, nrsp, nrdp;
  logic [7:0] sq[$];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  sup_packer #(.MS_CYC(10)) uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
    .ser_rx_ready(ser_rx_ready), .ser_tx_valid(ser_tx_valid), .ser_tx_data(ser_tx_data),
    .ser_tx_ready(ser_tx_ready), .net_tx_valid(ntv), .net_tx_data(ntd), .net_tx_last(ntl),
    .net_tx_dst_ip(nti), .net_tx_dst_port(ntp), .net_tx_ready(ntr), .net_rx_valid(nrv),
    .net_rx_data(nrd), .net_rx_last(nrl), .net_rx_src_ip(nri), .net_rx_src_port(nrsp),
    .net_rx_dst_port(nrdp), .net_rx_ready(nrr));
  sup_net_host host (.clk(clk), .slow(slow), .net_tx_valid(ntv), .net_tx_data(ntd), .net_tx_last(ntl),
    .net_tx_dst_ip(nti), .net_tx_dst_port(ntp), .net_tx_ready(ntr), .net_rx_valid(nrv),
    .net_rx_data(nrd), .net_rx_last(nrl), .net_rx_src_ip(nri), .net_rx_src_port(nrsp),
    .net_rx_dst_port(nrdp), .net_rx_ready(nrr));
  // serial transmitter takes a byte only every other cycle
  always @(posedge clk) begin
    ser_tx_ready <= ~ser_tx_ready;
    if (ser_tx_valid && ser_tx_ready) sq.push_back(ser_tx_data);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test;
    end
  end
  task automatic finish_test;
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic hw8(input logic [7:0] a, input logic wr);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(negedge clk);
    while (!hreadyout) @(negedge clk);
    @(posedge clk);
    hsel <= 0;
    htrans <= 2'h0;
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    hw8(a, 1);
    hwdata <= d;
    @(negedge clk);
    while (!hreadyout) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic brd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    hw8(a, 0);
    @(negedge clk);
    while (!hreadyout) @(negedge clk);
    d = hrdata;
    @(posedge clk);
    chk("reg", e, d);
    chk("hresp", 32'h00000000, 32'(hresp));
  endtask
  task automatic snd(input logic [7:0] tx[$]);
    foreach (tx[i]) begin
      ser_rx_valid <= 1;
      ser_rx_data <= tx[i];
      @(negedge clk);
      while (!ser_rx_ready) @(negedge clk);
      @(posedge clk);
    end
    ser_rx_valid <= 0;
    ser_rx_data <= ~ser_rx_data;
  endtask
  task automatic pk(input logic [7:0] tx[$], input logic [7:0] ex[$], input logic [31:0] ip);
    int n0;
    int k;
    n0 = host.ndg;
    snd(tx);
    k = 0;
    while (host.ndg == n0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk("dg_count", n0 + 1, host.ndg);
    chk("dg_len", ex.size(), host.dg.size());
    chk("dg_ip", ip, host.dg_ip);
    foreach (ex[i]) if (i < host.dg.size()) chk("dg_byte", ex[i], host.dg[i]);
  endtask
  task automatic wrx(input int n);
    int k;
    k = 0;
    while (sq.size() < n && k < 200) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic t_regs;
    brd(OFS_LISTEN, {16'h0000, LISTEN_PORT_RST});
    brd(8'h28, 32'h00000FA1);
    bw(8'hF0, 32'hFFFFFFFF);
    brd(8'hF0, 32'h00000000);
    bw(8'h20, IP_A);
    bw(8'h24, IP_A);
    bw(8'h28, 32'h00010FA1);
    brd(8'h28, 32'h00010FA1);
  endtask
  task automatic t_count;
    bw(OFS_PACK, 32'h00000003);
    bw(OFS_CTRL, 32'h00000D10);
    pk('{8'h41, 8'h0D, 8'h42}, '{8'h41, 8'h0D, 8'h42}, IP_A);
  endtask
  task automatic t_delim;
    bw(OFS_PACK, 32'h00000000);
    snd('{8'h41, 8'h42});
    // a long pause with the gap timer off must not flush
    repeat (200) @(posedge clk);
    pk('{8'h0D}, '{8'h41, 8'h42, 8'h0D}, IP_A);
  endtask
  task automatic t_plus;
    logic [7:0] q[$];
    for (int p = 1; p < 3; p++) begin
      bw(OFS_CTRL, 32'h00000D10 | (p << 2));
      q = '{8'h41, 8'h0D, 8'h51};
      if (p == 2) q.push_back(8'h52);
      pk(q, q, IP_A);
    end
  endtask
  task automatic t_strip;
    bw(OFS_CTRL, 32'h000A0D3C);
    pk('{8'h41, 8'h0D, 8'h42, 8'h0D, 8'h0A}, '{8'h41, 8'h0D, 8'h42}, IP_A);
  endtask
  task automatic t_gap;
    bw(OFS_CTRL, 32'h00000000);
    bw(OFS_GAP, 32'h00000001);
    pk('{8'h61, 8'h62}, '{8'h61, 8'h62}, IP_A);
    bw(OFS_GAP, 32'h00000000);
  endtask
  task automatic t_ceil;
    logic [7:0] q[$];
    for (int i = 0; i < 1024; i++) q.push_back(i[7:0]);
    slow <= 1;
    pk(q, q, IP_A);
    slow <= 0;
  endtask
  task automatic t_rng;
    int n0;
    bw(OFS_PACK, 32'h00000001);
    bw(8'h24, 32'h0A000006);
    bw(8'h30, 32'h0A0000FF);
    bw(8'h38, 32'h00010FA1);
    n0 = host.ndg;
    pk('{8'h33}, '{8'h33}, IP_A);
    repeat (40) @(posedge clk);
    chk("dg_count", n0 + 3, host.ndg);
    chk("dg_ip", 32'h0A0000FF, host.dg_ip);
  endtask
  task automatic t_rx;
    sq = {};
    host.send(IP_B, 16'h5555, 16'h0FA2, '{8'h99});
    host.send(IP_B, 16'h5555, LISTEN_PORT_RST, '{8'h01, 8'h02, 8'h03});
    wrx(3);
    chk("rx_len", 3, sq.size());
    foreach (sq[i]) chk("rx_byte", i + 1, sq[i]);
  endtask
  task automatic t_dyn;
    bw(OFS_CTRL, 32'h00000001);
    bw(OFS_PACK, 32'h00000002);
    sq = {};
    host.send(IP_B, 16'h1234, LISTEN_PORT_RST, '{8'h07});
    wrx(1);
    brd(OFS_PEER_IP, IP_B);
    pk('{8'h71, 8'h72}, '{8'h71, 8'h72}, IP_B);
    chk("dg_port", 32'h00001234, host.dg_port);
    bw(OFS_DTMO, 32'h00000003);
    sq = {};
    host.send(IP_B, 16'h1234, LISTEN_PORT_RST, '{8'h08});
    host.send(IP_A, 16'h4321, LISTEN_PORT_RST, '{8'h09});
    brd(OFS_PEER_IP, IP_B);
    repeat (40) @(posedge clk);
    brd(OFS_STATUS, 32'h00000000);
    chk("rx_len", 1, sq.size());
  endtask
  initial begin
    rst = 1;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
    ser_rx_valid = 0;
    ser_rx_data = 0;
    ser_tx_ready = 0;
    slow = 0;
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs;
    t_count;
    t_delim;
    t_plus;
    t_strip;
    t_gap;
    t_ceil;
    t_rng;
    t_rx;
    t_dyn;
    finish_test;
  end
endmodule
`default_nettype wire
